/* verilog/phy_lat_cfg.svh */
// Timing constants, symbol codes and reset values of the PHY latency datapath.
`ifndef PHY_LAT_CFG_SVH
`define PHY_LAT_CFG_SVH

`define CLK_NS 4
`define BIT10_NS 100
`define BIT100_NS 10
`define BIT10_CYC ((`BIT10_NS + `CLK_NS - 1) / `CLK_NS)
`define BIT100_CYC (`BIT100_NS / `CLK_NS)
`define MII_HALF10_CYC ((4 * `BIT10_NS) / (2 * `CLK_NS))
`define MII_HALF100_CYC ((4 * `BIT100_NS) / (2 * `CLK_NS))
`define TX10_MAX_BITS 2
`define TX10_MAX_CYC ((`TX10_MAX_BITS * `BIT10_NS) / `CLK_NS)
`define TX100_MAX_BITS 3
`define TX100_MAX_CYC ((`TX100_MAX_BITS * `BIT100_NS) / `CLK_NS)
`define CRS_ON_MAX_BITS 2
`define CRS_ON_MAX_CYC ((`CRS_ON_MAX_BITS * `BIT10_NS) / `CLK_NS)
`define CRS_OFF_MAX_BITS 4
`define CRS_OFF_MAX_CYC ((`CRS_OFF_MAX_BITS * `BIT10_NS) / `CLK_NS)
`define CRS_OFF_TYP_BITS 2
`define CRS_HOLD10_CYC ((`CRS_OFF_TYP_BITS * `BIT10_NS) / `CLK_NS)
`define CRS_HOLD100_CYC ((`CRS_OFF_TYP_BITS * `BIT100_NS) / `CLK_NS)
`define POR_TYP_MS 45
`define HWRST_TYP_MS 35
`define POR_CYC ((`POR_TYP_MS * 1000000) / `CLK_NS)
`define HWRST_CYC ((`HWRST_TYP_MS * 1000000) / `CLK_NS)
`define RX_IDLE_CYC 64
`define SYM_J 5'h18
`define SYM_K 5'h11
`define PREAMBLE_NIB 4'h5
`define PREAMBLE_LINE 4'hA
`define PIN_RESET_VAL 10'h200
`define FIFO_DEPTH 8
`define NIB_W 4

`endif

/* verilog/phy_lat_pkg.sv */
// Types shared by the PHY latency datapath.
package phy_lat_pkg;

   typedef enum logic [1:0] {
      T_IDLE = 2'h0,
      T_SYM = 2'h1,
      T_DATA = 2'h3,
      T_WAIT = 2'h2
   } tx_st_t;

   typedef enum logic [1:0] {
      R_HUNT = 2'h0,
      R_K = 2'h1,
      R_DATA = 2'h3
   } rx_st_t;

   typedef struct packed {
      logic rst_n;
      logic spd100;
      logic fdx;
      logic tx_en;
      logic [3:0] txd;
      logic rx_bit;
      logic rx_clk;
   } pin_t;

endpackage

/* verilog/nib_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps

module nib_fifo #(
   parameter int W = 4,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW + 1)'(D);
   localparam logic [AW-1:0] LAST = AW'(D - 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fst_t;

   fst_t st_ff;
   fst_t nxt_st;
   logic push;
   logic pop;

   assign in_ready_out = (st_ff.cnt != FULL);
   assign out_valid_out = (st_ff.cnt != '0);
   assign out_data_out = st_ff.mem[st_ff.rp];

   always_comb begin
      nxt_st = st_ff;
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_data_in;
         nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
      end
      if (push && !pop) begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (pop && !push) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule

/* verilog/phy_lat_core.sv */
// PHY datapath: MII nibbles to line bits and back, carrier sense and reset completion.
`include "phy_lat_cfg.svh"
`timescale 1ns/1ps

module phy_lat_core
   import phy_lat_pkg::*;
#(
   parameter int POR_CYC = `POR_CYC,
   parameter int HWRST_CYC = `HWRST_CYC
) (
   // Clock and power-on reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Hardware reset pin and mode straps
   input wire logic phy_reset_n_in,
   input wire logic speed_100_in,
   input wire logic full_duplex_in,
   // MII transmit side
   output logic mii_tx_clk_out,
   input wire logic mii_tx_en_in,
   input wire logic [3:0] mii_txd_in,
   // MII receive side
   output logic mii_rx_clk_out,
   output logic mii_rx_dv_out,
   output logic [3:0] mii_rxd_out,
   output logic mii_crs_out,
   // Line side
   output logic line_transmit_pair_out,
   output logic line_tx_active_out,
   input wire logic line_receive_pair_in,
   input wire logic line_rx_clk_in
);
   typedef struct packed {
      pin_t s1;
      pin_t s2;
      logic rxclk_d;
      logic ready;
      logic hw;
      logic [23:0] wcnt;
      logic [6:0] tdiv;
      logic txclk;
      tx_st_t tst;
      logic [9:0] tsh;
      logic [3:0] tbits;
      logic [4:0] tbcnt;
      logic [3:0] tnib;
      logic tline;
      logic tact;
      logic crs_tx;
      logic [6:0] chold;
      logic crs;
      rx_st_t rst;
      logic [4:0] rsh;
      logic [2:0] rbits;
      logic [3:0] rnib;
      logic [6:0] ridle;
      logic [3:0] rxd;
      logic rdv;
      logic rclk;
   } st_t;

   localparam logic [23:0] POR_LAST = 24'(POR_CYC - 1);
   localparam logic [23:0] HW_LAST = 24'(HWRST_CYC - 1);
   localparam int CRS_ON_MAX = `CRS_ON_MAX_CYC;
   localparam int CRS_OFF_MAX = `CRS_OFF_MAX_CYC;
   localparam int TX10_MAX = `TX10_MAX_CYC;
   localparam int TX100_MAX = `TX100_MAX_CYC;

   st_t st_ff;
   st_t nxt_st;
   pin_t pins;
   logic tick_rise;
   logic rx_edge;
   logic bit_end;
   logic want;
   logic [6:0] half_last;
   logic [4:0] bit_last;
   logic f_in_ready;
   logic f_out_valid;
   logic f_out_ready;
   logic [3:0] f_data;

   assign pins = '{rst_n: phy_reset_n_in, spd100: speed_100_in, fdx: full_duplex_in,
                   tx_en: mii_tx_en_in, txd: mii_txd_in, rx_bit: line_receive_pair_in,
                   rx_clk: line_rx_clk_in};

   // Never fills in practice: the serializer drains a nibble at least as fast as MII delivers one.
   nib_fifo #(.W(`NIB_W), .D(`FIFO_DEPTH)) u_fifo (
      .clk_in(clk_in),
      .rst_in(rst_in || !st_ff.ready),
      .in_valid_in(tick_rise && st_ff.s2.tx_en),
      .in_ready_out(f_in_ready),
      .in_data_in(st_ff.s2.txd),
      .out_valid_out(f_out_valid),
      .out_ready_in(f_out_ready),
      .out_data_out(f_data)
   );

   always_comb begin
      nxt_st = st_ff;
      tick_rise = 1'b0;
      bit_end = 1'b0;
      want = 1'b0;
      f_out_ready = 1'b0;
      nxt_st.s1 = pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.rxclk_d = st_ff.s2.rx_clk;
      rx_edge = st_ff.s2.rx_clk && !st_ff.rxclk_d;
      half_last = st_ff.s2.spd100 ? 7'(`MII_HALF100_CYC - 1) : 7'(`MII_HALF10_CYC - 1);
      bit_last = st_ff.s2.spd100 ? 5'(`BIT100_CYC - 1) : 5'(`BIT10_CYC - 1);
      if (!st_ff.s2.rst_n) begin
         nxt_st.ready = 1'b0;
         nxt_st.hw = 1'b1;
         nxt_st.wcnt = '0;
      end else if (!st_ff.ready) begin
         nxt_st.wcnt = st_ff.wcnt + 24'h1;
         if (st_ff.wcnt == (st_ff.hw ? HW_LAST : POR_LAST)) begin
            nxt_st.ready = 1'b1;
         end
      end
      if (!st_ff.ready) begin
         // Everything the MAC sees stays quiet until reset has completed.
         nxt_st.tdiv = '0;
         nxt_st.txclk = 1'b0;
         nxt_st.tst = T_IDLE;
         nxt_st.tact = 1'b0;
         nxt_st.tline = 1'b0;
         nxt_st.crs_tx = 1'b0;
         nxt_st.rst = R_HUNT;
         nxt_st.rdv = 1'b0;
         nxt_st.rxd = '0;
         nxt_st.rsh = '0;
         nxt_st.rbits = '0;
         nxt_st.ridle = '0;
      end else begin
         if (st_ff.tdiv >= half_last) begin
            nxt_st.tdiv = '0;
            nxt_st.txclk = !st_ff.txclk;
            tick_rise = !st_ff.txclk;
         end else begin
            nxt_st.tdiv = st_ff.tdiv + 7'h01;
         end
         if (st_ff.tact) begin
            if (st_ff.tbcnt == '0) begin
               bit_end = 1'b1;
            end else begin
               nxt_st.tbcnt = st_ff.tbcnt - 5'h01;
            end
         end
         if (bit_end && st_ff.tbits > 4'h1) begin
            nxt_st.tsh = {st_ff.tsh[8:0], 1'b0};
            nxt_st.tbits = st_ff.tbits - 4'h1;
            nxt_st.tbcnt = bit_last;
            nxt_st.tline = st_ff.tsh[8];
         end else begin
            case (st_ff.tst)
               T_IDLE: begin
                  want = f_out_valid;
               end
               T_SYM: begin
                  if (bit_end) begin
                     nxt_st.tsh = {st_ff.tnib[0], st_ff.tnib[1], st_ff.tnib[2], st_ff.tnib[3],
                                   6'h00};
                     nxt_st.tbits = 4'h4;
                     nxt_st.tbcnt = bit_last;
                     nxt_st.tline = st_ff.tnib[0];
                     nxt_st.tst = T_DATA;
                  end
               end
               T_DATA: begin
                  if (bit_end) begin
                     if (f_out_valid) begin
                        want = 1'b1;
                     end else if (st_ff.s2.tx_en) begin
                        nxt_st.tst = T_WAIT;
                        nxt_st.tbcnt = '0;
                     end else begin
                        nxt_st.tst = T_IDLE;
                        nxt_st.tact = 1'b0;
                        nxt_st.tline = 1'b0;
                     end
                  end
               end
               default: begin
                  if (f_out_valid) begin
                     want = 1'b1;
                  end else if (!st_ff.s2.tx_en) begin
                     nxt_st.tst = T_IDLE;
                     nxt_st.tact = 1'b0;
                     nxt_st.tline = 1'b0;
                  end
               end
            endcase
         end
         if (want) begin
            f_out_ready = 1'b1;
            nxt_st.tact = 1'b1;
            nxt_st.tbcnt = bit_last;
            if (st_ff.tst == T_IDLE && st_ff.s2.spd100) begin
               nxt_st.tsh = {`SYM_J, `SYM_K};
               nxt_st.tbits = 4'hA;
               nxt_st.tnib = f_data;
               nxt_st.tline = 1'b1;
               nxt_st.tst = T_SYM;
            end else begin
               nxt_st.tsh = {f_data[0], f_data[1], f_data[2], f_data[3], 6'h00};
               nxt_st.tbits = 4'h4;
               nxt_st.tline = f_data[0];
               nxt_st.tst = T_DATA;
            end
         end
         if (st_ff.s2.tx_en && !st_ff.s2.fdx) begin
            nxt_st.crs_tx = 1'b1;
            nxt_st.chold = st_ff.s2.spd100 ? 7'(`CRS_HOLD100_CYC - 1) :
                           7'(`CRS_HOLD10_CYC - 1);
         end else if (st_ff.crs_tx) begin
            if (st_ff.chold == '0) begin
               nxt_st.crs_tx = 1'b0;
            end else begin
               nxt_st.chold = st_ff.chold - 7'h01;
            end
         end
         if (rx_edge) begin
            nxt_st.ridle = '0;
         end else if (st_ff.ridle != 7'(`RX_IDLE_CYC)) begin
            nxt_st.ridle = st_ff.ridle + 7'h01;
         end
         // The line clock stands still between frames, so its silence ends the frame.
         if (st_ff.ridle == 7'(`RX_IDLE_CYC) && st_ff.rst != R_HUNT) begin
            nxt_st.rst = R_HUNT;
            nxt_st.rdv = 1'b0;
            nxt_st.rsh = '0;
         end else if (rx_edge) begin
            case (st_ff.rst)
               R_HUNT: begin
                  nxt_st.rsh = {st_ff.rsh[3:0], st_ff.s2.rx_bit};
                  if (!st_ff.s2.spd100 && {st_ff.rsh[2:0], st_ff.s2.rx_bit} == `PREAMBLE_LINE) begin
                     nxt_st.rxd = `PREAMBLE_NIB;
                     nxt_st.rdv = 1'b1;
                     nxt_st.rbits = '0;
                     nxt_st.rst = R_DATA;
                  end else if (st_ff.s2.spd100 && {st_ff.rsh[3:0], st_ff.s2.rx_bit} == `SYM_J) begin
                     nxt_st.rxd = `PREAMBLE_NIB;
                     nxt_st.rdv = 1'b1;
                     nxt_st.rbits = '0;
                     nxt_st.rst = R_K;
                  end
               end
               R_K: begin
                  if (st_ff.rbits == 3'h4) begin
                     nxt_st.rbits = '0;
                     nxt_st.rst = R_DATA;
                  end else begin
                     nxt_st.rbits = st_ff.rbits + 3'h1;
                  end
               end
               default: begin
                  nxt_st.rnib = {st_ff.s2.rx_bit, st_ff.rnib[3:1]};
                  if (st_ff.rbits == 3'h3) begin
                     nxt_st.rxd = {st_ff.s2.rx_bit, st_ff.rnib[3:1]};
                     nxt_st.rbits = '0;
                  end else begin
                     nxt_st.rbits = st_ff.rbits + 3'h1;
                  end
               end
            endcase
         end
      end
      nxt_st.crs = nxt_st.crs_tx || nxt_st.rdv;
      nxt_st.rclk = nxt_st.rdv ? nxt_st.rbits[1] : nxt_st.txclk;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_ff <= '0;
         st_ff.s1 <= `PIN_RESET_VAL;
         st_ff.s2 <= `PIN_RESET_VAL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mii_tx_clk_out = st_ff.txclk;
   assign mii_rx_clk_out = st_ff.rclk;
   assign mii_rx_dv_out = st_ff.rdv;
   assign mii_rxd_out = st_ff.rxd;
   assign mii_crs_out = st_ff.crs;
   assign line_transmit_pair_out = st_ff.tline;
   assign line_tx_active_out = st_ff.tact;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_tx_start(bit spd);
      tick_rise && st_ff.s2.tx_en && st_ff.s2.spd100 == spd && st_ff.tst == T_IDLE &&
      !f_out_valid;
   endsequence

   property p_crs_on;
      $rose(st_ff.s2.tx_en) && st_ff.ready && !st_ff.s2.fdx && !st_ff.s2.spd100
      |-> ##[0:CRS_ON_MAX] mii_crs_out;
   endproperty
   a_crs_on: assert property (p_crs_on) else $error("carrier sense rose too late");

   property p_crs_off;
      $fell(st_ff.s2.tx_en) && st_ff.ready && !st_ff.s2.fdx && !st_ff.s2.spd100
      |-> ##[0:CRS_OFF_MAX] !st_ff.crs_tx;
   endproperty
   a_crs_off: assert property (p_crs_off) else $error("carrier sense held too long");

   property p_tx10_first;
      s_tx_start(1'b0) |-> ##[1:TX10_MAX] (line_tx_active_out &&
                                          line_transmit_pair_out == $past(st_ff.s2.txd[0], 2));
   endproperty
   a_tx10_first: assert property (p_tx10_first) else $error("10M first bit late");

   property p_tx100_first;
      s_tx_start(1'b1) |-> ##[1:TX100_MAX] (line_tx_active_out && line_transmit_pair_out);
   endproperty
   a_tx100_first: assert property (p_tx100_first) else $error("start symbol late");

   property p_rx10_sof;
      rx_edge && st_ff.ready && st_ff.rst == R_HUNT && !st_ff.s2.spd100 &&
      {st_ff.rsh[2:0], st_ff.s2.rx_bit} == `PREAMBLE_LINE
      |=> mii_rx_dv_out && mii_rxd_out == `PREAMBLE_NIB;
   endproperty
   a_rx10_sof: assert property (p_rx10_sof) else $error("10M preamble not shown");

   property p_rx100_sof;
      $rose(mii_rx_dv_out) && st_ff.s2.spd100 |-> mii_rxd_out == `PREAMBLE_NIB &&
      st_ff.rst == R_K && $past(st_ff.rsh[3:0]) == 4'hC;
   endproperty
   a_rx100_sof: assert property (p_rx100_sof) else $error("start symbol not shown");

   property p_idle_until_ready;
      !st_ff.ready |=> !mii_crs_out && !mii_rx_dv_out && !mii_tx_clk_out;
   endproperty
   a_idle_until_ready: assert property (p_idle_until_ready) else $error("active before reset done");

   property p_hw_reset;
      !st_ff.s2.rst_n |=> !st_ff.ready ##1 !mii_tx_clk_out;
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("hardware reset ignored");

   property p_ready_hold;
      st_ff.ready && st_ff.s2.rst_n |=> st_ff.ready;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");

   property p_txclk100;
      $rose(mii_tx_clk_out) && st_ff.s2.spd100 && st_ff.s1.spd100 && st_ff.s2.rst_n
      && st_ff.s1.rst_n |-> mii_tx_clk_out[*5] ##1 !mii_tx_clk_out;
   endproperty
   a_txclk100: assert property (p_txclk100) else $error("100M clock half period wrong");

endmodule

/* verif/mac_model.sv */
// Behavioural MAC that sends nibble frames on the MII transmit side.
`timescale 1ns/1ps

module mac_model (
   // Clocks
   input wire logic clk_in,
   input wire logic tx_clk_in,
   // MII transmit side
   output logic tx_en_out,
   output logic [3:0] txd_out
);
   initial begin
      tx_en_out = 1'b0;
      txd_out = 4'h0;
   end

   // Drives on the transmit clock's fall, so each nibble is settled long before the rise.
   task automatic send(input logic [31:0] nibs);
      int i;
      for (i = 0; i < 8; i++) begin
         @(negedge tx_clk_in);
         @(negedge clk_in);
         tx_en_out = 1'b1;
         txd_out = nibs[4*i +: 4];
      end
      @(negedge tx_clk_in);
      @(negedge clk_in);
      tx_en_out = 1'b0;
      txd_out = ~txd_out;
   endtask
endmodule

/* verif/testbench.sv */
// Self-checking testbench of the PHY latency datapath and its nibble FIFO.
`timescale 1ns/1ps
`include "phy_lat_cfg.svh"

`define CHK(a, e, m) check_val((a) === (e), m)

module testbench;
   typedef logic bitq_t[$];
   localparam int POR = 200;
   localparam int HWR = 100;
   logic clk_in, rst_in, phy_reset_n_in, speed_100_in, full_duplex_in;
   logic mii_tx_clk_out, mii_tx_en_in, mii_rx_clk_out, mii_rx_dv_out, mii_crs_out;
   logic [3:0] mii_txd_in, mii_rxd_out, rxd_first;
   logic line_transmit_pair_out, line_tx_active_out, line_receive_pair_in, line_rx_clk_in;
   logic taking;
   logic [31:0] seed;
   time t_take, t_act, t_en_r, t_en_f, t_crs_r, t_crs_f, t_dv, t_first;
   int fails, n_checks;

   phy_lat_core #(.POR_CYC(POR), .HWRST_CYC(HWR)) DUT (.clk_in(clk_in), .rst_in(rst_in),
      .phy_reset_n_in(phy_reset_n_in), .speed_100_in(speed_100_in),
      .full_duplex_in(full_duplex_in), .mii_tx_clk_out(mii_tx_clk_out),
      .mii_tx_en_in(mii_tx_en_in), .mii_txd_in(mii_txd_in), .mii_rx_clk_out(mii_rx_clk_out),
      .mii_rx_dv_out(mii_rx_dv_out), .mii_rxd_out(mii_rxd_out), .mii_crs_out(mii_crs_out),
      .line_transmit_pair_out(line_transmit_pair_out), .line_tx_active_out(line_tx_active_out),
      .line_receive_pair_in(line_receive_pair_in), .line_rx_clk_in(line_rx_clk_in));
   mac_model mac (.clk_in(clk_in), .tx_clk_in(mii_tx_clk_out), .tx_en_out(mii_tx_en_in),
      .txd_out(mii_txd_in));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   // Edge times of the observed signals; latencies are judged from them afterwards.
   always @(posedge mii_tx_clk_out) begin
      if (mii_tx_en_in && !taking) begin
         t_take = $time;
         taking = 1'b1;
      end else if (!mii_tx_en_in) begin
         taking = 1'b0;
      end
   end
   always @(posedge line_tx_active_out) t_act = $time;
   always @(posedge mii_tx_en_in) t_en_r = $time;
   always @(negedge mii_tx_en_in) t_en_f = $time;
   always @(posedge mii_crs_out) t_crs_r = $time;
   always @(negedge mii_crs_out) t_crs_f = $time;
   always @(posedge mii_rx_dv_out) begin
      t_dv = $time;
      #1 rxd_first = mii_rxd_out;
   end

   task automatic check_val(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [31:0] rnd();
      int i;
      for (i = 0; i < 32; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Line bit order: symbols MSB first at 100M, preamble and nibbles LSB first.
   function automatic bitq_t exp_bits(input logic hundred, input logic [31:0] d, input logic rx);
      bitq_t q;
      int i;
      logic [9:0] jk;
      logic [3:0] pre;
      jk = {`SYM_J, `SYM_K};
      pre = `PREAMBLE_NIB;
      if (hundred) begin
         for (i = 9; i >= 0; i--) q.push_back(jk[i]);
      end else if (rx) begin
         for (i = 0; i < 4; i++) q.push_back(pre[i]);
      end
      for (i = 0; i < 32; i++) q.push_back(d[i]);
      return q;
   endfunction

   task automatic wait_ready(input int lo);
      int k;
      logic quiet;
      quiet = 1'b1;
      k = 0;
      while (k < lo) begin
         quiet &= (mii_tx_clk_out === 1'b0 && mii_crs_out === 1'b0 && mii_rx_dv_out === 1'b0);
         @(negedge clk_in);
         k++;
      end
      `CHK(quiet, 1'b1, "outputs active before ready");
      while (mii_tx_clk_out !== 1'b1 && k < lo + 2 * `MII_HALF10_CYC + 8) begin
         @(negedge clk_in);
         k++;
      end
      `CHK(mii_tx_clk_out, 1'b1, "transmit clock late");
   endtask

   // The link clock runs only within a frame and off the system clock's edges.
   task automatic line_drive(input bitq_t q, input int hdr, input logic [31:0] d, input logic chk);
      @(negedge clk_in);
      #1.3;
      foreach (q[i]) begin
         if (chk && i > hdr && (i - hdr) % 4 == 0)
            `CHK(mii_rxd_out, d[4*((i-hdr)/4-1) +: 4], "receive nibble");
         line_receive_pair_in = q[i];
         #40 line_rx_clk_in = 1'b1;
         if (i == 0) t_first = $time;
         #40 line_rx_clk_in = 1'b0;
      end
      if (chk) `CHK(mii_rxd_out, d[31:28], "last receive nibble");
      line_receive_pair_in = ~line_receive_pair_in;
   endtask

   task automatic tx_case(input logic hundred, input logic fdx);
      logic [31:0] d;
      bitq_t q;
      int k, p;
      d = rnd();
      p = hundred ? `BIT100_CYC : `BIT10_CYC;
      q = exp_bits(hundred, d, 1'b0);
      speed_100_in = hundred;
      full_duplex_in = fdx;
      repeat (120) @(negedge clk_in);
      fork
         mac.send(d);
         begin
            k = 0;
            while (line_tx_active_out !== 1'b1 && k < 800) begin
               @(negedge clk_in);
               k++;
            end
            if (hundred) `CHK(t_act - t_take <= `TX100_MAX_CYC * `CLK_NS, 1'b1, "J late");
            else `CHK(t_act - t_take <= `TX10_MAX_CYC * `CLK_NS, 1'b1, "first bit late");
            repeat (p / 2) @(negedge clk_in);
            foreach (q[i]) begin
               `CHK(line_transmit_pair_out, q[i], "line bit");
               repeat (p) @(negedge clk_in);
            end
         end
      join
      k = 0;
      while (line_tx_active_out !== 1'b0 && k < 300) begin
         @(negedge clk_in);
         k++;
      end
      `CHK({line_tx_active_out, line_transmit_pair_out}, 2'b00, "line not idle");
      repeat (60) @(negedge clk_in);
      if (!hundred && fdx) `CHK(t_crs_r < t_en_r, 1'b1, "carrier in full duplex");
      if (!hundred && !fdx) begin
         `CHK(t_crs_r >= t_en_r && t_crs_r - t_en_r <= (`CRS_ON_MAX_CYC + 3) * `CLK_NS, 1'b1,
            "carrier on");
         `CHK(t_crs_f > t_en_f && t_crs_f - t_en_f <= (`CRS_OFF_MAX_CYC + 3) * `CLK_NS, 1'b1,
            "carrier off");
      end
   endtask

   task automatic rx_case(input logic hundred);
      logic [31:0] d;
      d = rnd();
      speed_100_in = hundred;
      repeat (120) @(negedge clk_in);
      line_drive(exp_bits(hundred, d, 1'b1), hundred ? 10 : 4, d, 1'b1);
      if (hundred) `CHK(t_dv - t_first <= 17 * 80, 1'b1, "J late on receive");
      else `CHK(t_dv - t_first <= 7 * 80, 1'b1, "preamble late on receive");
      `CHK(rxd_first, `PREAMBLE_NIB, "first receive nibble");
      repeat (`RX_IDLE_CYC + 16) @(negedge clk_in);
      `CHK(mii_rx_dv_out, 1'b0, "receive valid after silence");
   endtask

   initial begin
      #200000;
      fails++;
      $display("wrong value at %0t: timeout", $time);
      finish_test();
   end

   initial begin
      bitq_t pq;
      pq = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      seed = 32'h963E;
      fails = 0;
      n_checks = 0;
      taking = 1'b0;
      {t_take, t_act, t_en_r, t_en_f, t_crs_r, t_crs_f, t_dv, t_first} = '0;
      rst_in = 1'b1;
      phy_reset_n_in = 1'b1;
      {speed_100_in, full_duplex_in, line_receive_pair_in, line_rx_clk_in} = 4'h0;
      repeat (6) @(negedge clk_in);
      `CHK({mii_tx_clk_out, mii_crs_out, mii_rx_dv_out, line_tx_active_out}, 4'h0,
         "outputs in reset");
      rst_in = 1'b0;
      fork
         wait_ready(POR - 3);
         line_drive(pq, 4, 32'h0, 1'b0);
      join
      tx_case(1'b0, 1'b0);
      tx_case(1'b0, 1'b1);
      tx_case(1'b1, 1'b0);
      rx_case(1'b0);
      rx_case(1'b1);
      speed_100_in = 1'b0;
      repeat (20) @(negedge clk_in);
      phy_reset_n_in = 1'b0;
      repeat (60) @(negedge clk_in);
      `CHK({mii_tx_clk_out, mii_crs_out}, 2'b00, "outputs in hardware reset");
      phy_reset_n_in = 1'b1;
      wait_ready(HWR - 3);
      // The nibble buffer is emptied by hardware reset, so a frame after it checks its order.
      tx_case(1'b0, 1'b0);
      tx_case(1'b1, 1'b1);
      finish_test();
   end
endmodule
